// File: dv/epo_pulse_counter.sv
`timescale 1ns/1ns

module epo_pulse_counter (
    // Clock
    input wire logic hclk,
    // Observed lines: bits 3:0 channels, bit 4 indicator
    input wire logic [4:0] lines
);
    int rises[5];
    int edges[5];
    int hi_len[5];
    int period[5];
    int hi_run[5];
    int since[5];
    logic [4:0] prev = 5'h00;

    // ============================================================
    // Counts every transition and measures high time and period.
    always @(posedge hclk) begin
        for (int i = 0; i < 5; i++) begin
            if (lines[i] !== prev[i]) begin
                edges[i]++;
            end
            if (lines[i] && !prev[i]) begin
                rises[i]++;
                period[i] = since[i];
                since[i] = 0;
                hi_run[i] = 0;
            end
            if (!lines[i] && prev[i]) begin
                hi_len[i] = hi_run[i];
            end
            if (lines[i]) begin
                hi_run[i]++;
            end
            since[i]++;
        end
        prev = lines;
    end
endmodule

// File: dv/epo_top_checker.sv
`timescale 1ns/1ns
`include "epo_consts.svh"

module epo_top_checker #(
    parameter int CYCLES_PER_MS = 4
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    // Outputs
    input wire logic [3:0] channel_out,
    input wire logic led_out
);
    // ============================================================
    // Shadow of the calibration width and indicator run lengths
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [15:0] cal_w_r;
    logic cfg_seen_r;
    logic [31:0] hi_cnt_r;
    logic [31:0] lo_cnt_r;
    logic [31:0] w_eff;
    assign w_eff = (cal_w_r == 16'h0000) ? 32'h1 : {16'h0, cal_w_r};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else if (hready) begin
            wr_pend_r <= hsel && htrans[1] && hwrite;
            wr_addr_r <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_w_r <= `EPO_CAL_WIDTH_RST;
            cfg_seen_r <= 1'b0;
        end else if (wr_pend_r && hready) begin
            if (wr_addr_r == `EPO_ADDR_CAL_WIDTH) begin
                cal_w_r <= hwdata[15:0];
            end
            if (wr_addr_r == `EPO_ADDR_GEN_CTRL || wr_addr_r == `EPO_ADDR_CAL_CTRL) begin
                cfg_seen_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hi_cnt_r <= 32'h0;
            lo_cnt_r <= 32'h0;
        end else if (led_out) begin
            hi_cnt_r <= (lo_cnt_r != 32'h0) ? 32'h1 : hi_cnt_r + 32'h1;
            lo_cnt_r <= 32'h0;
        end else begin
            lo_cnt_r <= lo_cnt_r + 32'h1;
        end
    end

    // ============================================================
    // Properties
    sequence s_read_taken;
        hsel && htrans[1] && hready && !hwrite;
    endsequence
    sequence s_wait_data;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_read_wait;
        @(posedge hclk) disable iff (!hresetn) s_read_taken |=> s_wait_data;
    endproperty
    property p_write_no_wait;
        @(posedge hclk) disable iff (!hresetn) hsel && htrans[1] && hready && hwrite |=> hreadyout;
    endproperty
    property p_resp_okay;
        @(posedge hclk) disable iff (!hresetn) hresp == 1'b0;
    endproperty
    property p_one_wait;
        @(posedge hclk) disable iff (!hresetn) !hreadyout |=> hreadyout;
    endproperty
    property p_rdata_stands;
        @(posedge hclk) disable iff (!hresetn) $changed(hrdata) |-> !hreadyout || !$past(hreadyout);
    endproperty
    property p_unassigned_quiet;
        @(posedge hclk) disable iff (!hresetn) !cfg_seen_r |-> channel_out == 4'h0;
    endproperty
    property p_duty;
        @(posedge hclk) disable iff (!hresetn) $rose(led_out) |-> lo_cnt_r + CYCLES_PER_MS >= hi_cnt_r;
    endproperty
    property p_cal_width;
        @(posedge hclk) disable iff (!hresetn) $fell(led_out) |->
            hi_cnt_r >= (w_eff - 1) * CYCLES_PER_MS && hi_cnt_r <= (w_eff + 1) * CYCLES_PER_MS;
    endproperty

    a_read_wait: assert property (p_read_wait) else $error("read wait state wrong");
    a_write_no_wait: assert property (p_write_no_wait) else $error("write stalled");
    a_resp_okay: assert property (p_resp_okay) else $error("response not okay");
    a_one_wait: assert property (p_one_wait) else $error("ready low too long");
    a_rdata_stands: assert property (p_rdata_stands) else $error("read data moved");
    a_unassigned_quiet: assert property (p_unassigned_quiet) else $error("channel driven");
    a_duty: assert property (p_duty) else $error("indicator gap too short");
    a_cal_width: assert property (p_cal_width) else $error("indicator width wrong");
endmodule

bind epo_top epo_top_checker #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .channel_out(channel_out), .led_out(led_out)
);

// File: dv/tb.sv
`timescale 1ns/1ns
`include "epo_consts.svh"

module tb;
    localparam int CPM = 4;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, pulse_in, led_out;
    logic [31:0] haddr, hwdata, hrdata, d;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic signed [31:0] power_in;
    logic [3:0] channel_out;
    int fails, n_checks, r0;
    assign hready = hreadyout;

    always #5 hclk = ~hclk;

    epo_top #(.CYCLES_PER_MS(CPM)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .power_in(power_in),
        .pulse_in(pulse_in), .channel_out(channel_out), .led_out(led_out)
    );
    epo_pulse_counter pc (.hclk(hclk), .lines({led_out, channel_out}));

    // ============================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        n_checks++;
        if (got < lo || got > hi) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        d = hrdata;
    endtask
    task automatic fire();
        @(posedge hclk);
        pulse_in <= 1'b1;
        @(posedge hclk);
        pulse_in <= 1'b0;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset_vals();
        logic [7:0] a[7] = '{`EPO_ADDR_GEN_CTRL, `EPO_ADDR_GEN_WIDTH, `EPO_ADDR_CAL_CTRL,
            `EPO_ADDR_CAL_WIDTH, `EPO_ADDR_CAL_EPP, `EPO_ADDR_STATUS, 8'h1C};
        logic [31:0] e[7] = '{32'h0, `EPO_GEN_WIDTH_RST, 32'h0, `EPO_CAL_WIDTH_RST,
            `EPO_EPP_RST, 32'h0, 32'h0};
        for (int i = 0; i < 7; i++) begin
            bus(a[i], 1'b0, 32'h0);
            chk(d, e[i]);
        end
        $display("test reset_vals done");
    endtask

    task automatic t_general();
        logic l;
        bus(`EPO_ADDR_GEN_WIDTH, 1'b1, 32'h3);
        bus(`EPO_ADDR_GEN_WIDTH, 1'b0, 32'h0);
        chk(d, 32'h3);
        bus(`EPO_ADDR_GEN_CTRL, 1'b1, 32'h1);
        fire();
        idle(6 * CPM);
        chk(pc.rises[0], 1);
        chk_rng(pc.hi_len[0], 2 * CPM, 4 * CPM);
        chk(pc.edges[1] + pc.edges[2] + pc.edges[3], 0);
        bus(`EPO_ADDR_GEN_CTRL, 1'b1, 32'h21);
        idle(4);
        chk(channel_out, 4'h1);
        fire();
        idle(6);
        chk(channel_out[0], 1'b0);
        idle(6 * CPM);
        chk(channel_out, 4'h1);
        bus(`EPO_ADDR_GEN_CTRL, 1'b1, 32'h31);
        idle(4);
        r0 = pc.edges[0];
        l = channel_out[0];
        for (int i = 1; i <= 2; i++) begin
            fire();
            idle(6 * CPM);
            chk(pc.edges[0] - r0, i);
        end
        chk(channel_out[0], l);
        $display("test general done");
    endtask

    task automatic t_refuse();
        bus(`EPO_ADDR_CAL_CTRL, 1'b1, 32'h1);
        bus(`EPO_ADDR_CAL_CTRL, 1'b0, 32'h0);
        chk(d, 32'h0);
        bus(`EPO_ADDR_STATUS, 1'b0, 32'h0);
        chk(d[`EPO_ST_REJ_BIT], 1'b1);
        bus(`EPO_ADDR_STATUS, 1'b1, 32'h0);
        bus(`EPO_ADDR_STATUS, 1'b0, 32'h0);
        chk(d[`EPO_ST_REJ_BIT], 1'b0);
        bus(`EPO_ADDR_GEN_CTRL, 1'b1, 32'h5);
        bus(`EPO_ADDR_GEN_CTRL, 1'b0, 32'h0);
        chk(d, 32'h1);
        $display("test refuse done");
    endtask

    task automatic t_cal();
        bus(`EPO_ADDR_CAL_WIDTH, 1'b1, 32'h2);
        bus(`EPO_ADDR_CAL_EPP, 1'b1, 32'h1);
        bus(`EPO_ADDR_CAL_CTRL, 1'b1, 32'h14);
        @(posedge hclk);
        power_in <= 32'sd360;
        idle(100 * CPM);
        power_in <= 32'sd0;
        idle(20 * CPM);
        chk(pc.period[4], 10 * CPM);
        chk_rng(pc.rises[4], 9, 10);
        chk_rng(pc.hi_len[4], CPM, 3 * CPM);
        chk(pc.edges[3], pc.rises[4]);
        chk(pc.edges[1] + pc.edges[2], 0);
        bus(`EPO_ADDR_STATUS, 1'b0, 32'h0);
        chk(d[31:16], pc.rises[4]);
        // Exactly 100 ticks at 360 W fill ten whole quanta, so nothing is left over.
        bus(`EPO_ADDR_CAL_ACC, 1'b0, 32'h0);
        chk(d, 32'h0000_0000);
        $display("test calibration done");
    endtask

    task automatic t_int_modes();
        logic [1:0] m[4] = '{2'h0, 2'h2, 2'h1, 2'h3};
        logic e[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        power_in <= -32'sd360;
        for (int i = 0; i < 4; i++) begin
            bus(`EPO_ADDR_CAL_CTRL, 1'b1, {22'h0, m[i], 8'h04});
            idle(8);
            r0 = pc.rises[4];
            idle(30 * CPM);
            chk(pc.rises[4] != r0, e[i]);
        end
        power_in <= 32'sd0;
        $display("test int_modes done");
    endtask

    // ============================================================
    // Main sequence and watchdog
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        power_in = 32'sd0;
        pulse_in = 1'b0;
        idle(2);
        hresetn <= 1'b1;
        t_reset_vals();
        t_general();
        t_refuse();
        t_cal();
        t_int_modes();
        summarize();
    end

    initial begin
        idle(20000);
        fails++;
        $display("watchdog expired at %0t", $time);
        summarize();
    end
endmodule

// File: hdl/epo_consts.svh
`ifndef EPO_CONSTS_SVH
`define EPO_CONSTS_SVH

// ============================================================
// Register byte offsets
`define EPO_ADDR_GEN_CTRL 8'h00
`define EPO_ADDR_GEN_WIDTH 8'h04
`define EPO_ADDR_CAL_CTRL 8'h08
`define EPO_ADDR_CAL_WIDTH 8'h0C
`define EPO_ADDR_CAL_EPP 8'h10
`define EPO_ADDR_STATUS 8'h14
`define EPO_ADDR_CAL_ACC 8'h18

// ============================================================
// Control register fields
`define EPO_PORT_LSB 0
`define EPO_PORT_MSB 2
`define EPO_MODE_BIT 4
`define EPO_POL_BIT 5
`define EPO_INT_LSB 8
`define EPO_INT_MSB 9

// ============================================================
// Status register fields
`define EPO_ST_OUT_LSB 0
`define EPO_ST_OUT_MSB 3
`define EPO_ST_LED_BIT 4
`define EPO_ST_REJ_BIT 8
`define EPO_ST_CNT_LSB 16
`define EPO_ST_CNT_MSB 31

// ============================================================
// Reset values: widths in milliseconds, energy quantum in milli-watt-hours.
`define EPO_GEN_WIDTH_RST 16'h03E8
`define EPO_CAL_WIDTH_RST 16'h0032
`define EPO_EPP_RST 16'h0708
`define EPO_PORT_RST 3'h0
`define EPO_PORT_LAST 3'h4

// ============================================================
// Timing
`define EPO_CLK_PERIOD_NS 10
`define EPO_MS_NS 1000000
`define EPO_WMS_PER_MWH 3600
`define EPO_PEND_MAX 4'hF

`endif

// File: hdl/epo_pkg.sv
package epo_pkg;

    typedef enum logic [1:0] {
        EPO_INT_ABS = 2'h0,
        EPO_INT_FWD = 2'h1,
        EPO_INT_REV = 2'h2,
        EPO_INT_NET = 2'h3
    } epo_int_mode_t;

    typedef enum logic [2:0] {
        EPO_ST_IDLE = 3'b001,
        EPO_ST_HIGH = 3'b010,
        EPO_ST_GAP = 3'b100
    } epo_state_t;

    // Port code 0 is unassigned; 4 is solid_state_output_four.
    typedef struct packed {
        logic [2:0] port;
        logic kyz;
        logic invert;
        epo_int_mode_t int_mode;
    } epo_ctrl_t;

    typedef struct packed {
        logic [15:0] width_ms;
        logic kyz;
        logic invert;
        logic gap;
    } epo_shape_cfg_t;

endpackage

// File: hdl/epo_pulse_shaper.sv
`timescale 1ns/1ns
`include "epo_consts.svh"

module epo_pulse_shaper (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Timebase and events
    input wire logic tick,
    input wire logic event_in,
    input wire epo_pkg::epo_shape_cfg_t cfg,
    // Shaped level
    output logic level
);
    import epo_pkg::*;

    epo_state_t state_r;
    logic [15:0] cnt_r;
    logic [3:0] pend_r;
    logic pulse_r;
    logic kyz_r;
    logic [15:0] width_eff;
    logic start;
    logic cnt_done;

    assign width_eff = (cfg.width_ms == 16'h0000) ? 16'h0001 : cfg.width_ms;
    assign start = (state_r == EPO_ST_IDLE) && (pend_r != 4'h0);
    assign cnt_done = tick && (cnt_r <= 16'h0001);

    // ============================================================
    // Events that arrive while a pulse runs wait here.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pend_r <= 4'h0;
        end else if (event_in && !start && pend_r != `EPO_PEND_MAX) begin
            pend_r <= pend_r + 4'h1;
        end else if (!event_in && start) begin
            pend_r <= pend_r - 4'h1;
        end
    end

    // ============================================================
    // Pulse timing.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= EPO_ST_IDLE;
            cnt_r <= 16'h0000;
        end else begin
            case (state_r)
                EPO_ST_IDLE: begin
                    if (start) begin
                        state_r <= EPO_ST_HIGH;
                        cnt_r <= width_eff;
                    end
                end
                EPO_ST_HIGH: begin
                    if (cnt_done && cfg.gap) begin
                        state_r <= EPO_ST_GAP;
                        cnt_r <= width_eff;
                    end else if (cnt_done) begin
                        state_r <= EPO_ST_IDLE;
                    end else if (tick) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                EPO_ST_GAP: begin
                    if (cnt_done) begin
                        state_r <= EPO_ST_IDLE;
                    end else if (tick) begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                default: begin
                    state_r <= EPO_ST_IDLE;
                end
            endcase
        end
    end

    // ============================================================
    // Pulse and transition levels.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pulse_r <= 1'b0;
            kyz_r <= 1'b0;
        end else begin
            if (start && !cfg.kyz) begin
                pulse_r <= 1'b1;
            end else if (state_r == EPO_ST_HIGH && cnt_done) begin
                pulse_r <= 1'b0;
            end
            if (start && cfg.kyz) begin
                kyz_r <= ~kyz_r;
            end
        end
    end

    assign level = cfg.kyz ? kyz_r : (pulse_r ^ cfg.invert);

endmodule

// File: hdl/epo_top.sv
`timescale 1ns/1ns
`include "epo_consts.svh"


module epo_top #(
    parameter int CYCLES_PER_MS = `EPO_MS_NS / `EPO_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Measured power and pulse requests
    input wire logic signed [31:0] power_in,
    input wire logic pulse_in,
    // Pulse outputs
    output logic [3:0] channel_out,
    output logic led_out
);
    import epo_pkg::*;

    logic hreadyout_r;
    logic [31:0] hrdata_r;
    logic hresp_r;
    logic wr_pend_r;
    logic rd_pend_r;
    logic [7:0] addr_r;
    logic accept;

    epo_ctrl_t gen_ctrl_r;
    epo_ctrl_t cal_ctrl_r;
    logic [15:0] gen_width_r;
    logic [15:0] cal_width_r;
    logic [15:0] cal_epp_r;
    logic reject_r;
    logic [15:0] cal_count_r;

    logic [31:0] tick_cnt_r;
    logic tick_r;
    logic signed [47:0] acc_r;
    logic signed [47:0] contrib;
    logic signed [47:0] acc_sum;
    logic signed [47:0] thr;
    logic cal_evt_r;

    logic gen_lvl;
    logic cal_lvl;
    logic led_lvl;
    logic [3:0] channel_r;
    logic led_r;
    logic [31:0] rd_val;

    logic wr_en;
    logic [2:0] wr_port;
    logic port_bad;
    logic wr_gen_ctrl;
    logic wr_cal_ctrl;

    assign accept = hsel && htrans[1] && hready;
    assign wr_en = wr_pend_r;
    assign wr_port = hwdata[`EPO_PORT_MSB:`EPO_PORT_LSB];

    // ============================================================
    // Bus front end: writes take no wait state, reads take one.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r <= 8'h00;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            wr_pend_r <= accept && hwrite;
            rd_pend_r <= accept && !hwrite;
            hreadyout_r <= !(accept && !hwrite);
            hresp_r <= 1'b0;
            if (accept) begin
                addr_r <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_pend_r) begin
            hrdata_r <= rd_val;
        end
    end

    always_comb begin
        rd_val = 32'h0000_0000;
        case (addr_r)
            `EPO_ADDR_GEN_CTRL: begin
                rd_val[`EPO_PORT_MSB:`EPO_PORT_LSB] = gen_ctrl_r.port;
                rd_val[`EPO_MODE_BIT] = gen_ctrl_r.kyz;
                rd_val[`EPO_POL_BIT] = gen_ctrl_r.invert;
            end
            `EPO_ADDR_GEN_WIDTH: rd_val[15:0] = gen_width_r;
            `EPO_ADDR_CAL_CTRL: begin
                rd_val[`EPO_PORT_MSB:`EPO_PORT_LSB] = cal_ctrl_r.port;
                rd_val[`EPO_MODE_BIT] = cal_ctrl_r.kyz;
                rd_val[`EPO_INT_MSB:`EPO_INT_LSB] = cal_ctrl_r.int_mode;
            end
            `EPO_ADDR_CAL_WIDTH: rd_val[15:0] = cal_width_r;
            `EPO_ADDR_CAL_EPP: rd_val[15:0] = cal_epp_r;
            `EPO_ADDR_STATUS: begin
                rd_val[`EPO_ST_OUT_MSB:`EPO_ST_OUT_LSB] = channel_r;
                rd_val[`EPO_ST_LED_BIT] = led_r;
                rd_val[`EPO_ST_REJ_BIT] = reject_r;
                rd_val[`EPO_ST_CNT_MSB:`EPO_ST_CNT_LSB] = cal_count_r;
            end
            `EPO_ADDR_CAL_ACC: rd_val = acc_r[31:0];
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // ============================================================
    // Configuration registers.
    // A port write is refused when the code names no channel or one already
    // claimed by the other pulser; zero (unassigned) is always accepted.
    assign wr_gen_ctrl = wr_en && (addr_r == `EPO_ADDR_GEN_CTRL);
    assign wr_cal_ctrl = wr_en && (addr_r == `EPO_ADDR_CAL_CTRL);
    assign port_bad = (wr_port > `EPO_PORT_LAST) || ((wr_port != 3'h0) &&
        ((wr_gen_ctrl && wr_port == cal_ctrl_r.port) ||
         (wr_cal_ctrl && wr_port == gen_ctrl_r.port)));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_ctrl_r <= '{port: `EPO_PORT_RST, kyz: 1'b0, invert: 1'b0,
                            int_mode: EPO_INT_ABS};
            cal_ctrl_r <= '{port: `EPO_PORT_RST, kyz: 1'b0, invert: 1'b0,
                            int_mode: EPO_INT_ABS};
        end else begin
            if (wr_gen_ctrl) begin
                gen_ctrl_r.kyz <= hwdata[`EPO_MODE_BIT];
                gen_ctrl_r.invert <= hwdata[`EPO_POL_BIT];
                if (!port_bad) begin
                    gen_ctrl_r.port <= wr_port;
                end
            end
            if (wr_cal_ctrl) begin
                cal_ctrl_r.kyz <= hwdata[`EPO_MODE_BIT];
                cal_ctrl_r.int_mode <= epo_int_mode_t'(hwdata[`EPO_INT_MSB:`EPO_INT_LSB]);
                if (!port_bad) begin
                    cal_ctrl_r.port <= wr_port;
                end
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gen_width_r <= `EPO_GEN_WIDTH_RST;
            cal_width_r <= `EPO_CAL_WIDTH_RST;
            cal_epp_r <= `EPO_EPP_RST;
        end else if (wr_en) begin
            if (addr_r == `EPO_ADDR_GEN_WIDTH) begin
                gen_width_r <= hwdata[15:0];
            end
            if (addr_r == `EPO_ADDR_CAL_WIDTH) begin
                cal_width_r <= hwdata[15:0];
            end
            if (addr_r == `EPO_ADDR_CAL_EPP) begin
                cal_epp_r <= hwdata[15:0];
            end
        end
    end

    // Refusal flag: a new refusal wins over a clearing write to the status word.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            reject_r <= 1'b0;
        end else if ((wr_gen_ctrl || wr_cal_ctrl) && port_bad) begin
            reject_r <= 1'b1;
        end else if (wr_en && addr_r == `EPO_ADDR_STATUS) begin
            reject_r <= 1'b0;
        end
    end

    // ============================================================
    // Millisecond timebase.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b0;
        end else if (tick_cnt_r >= 32'(CYCLES_PER_MS - 1)) begin
            tick_cnt_r <= 32'h0000_0000;
            tick_r <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
            tick_r <= 1'b0;
        end
    end

    // ============================================================
    // Energy integration in watt-milliseconds, one sample per tick.
    always_comb begin
        contrib = 48'sh0;
        case (cal_ctrl_r.int_mode)
            EPO_INT_ABS: contrib = power_in[31] ? -48'(power_in) : 48'(power_in);
            EPO_INT_FWD: contrib = power_in[31] ? 48'sh0 : 48'(power_in);
            EPO_INT_REV: contrib = power_in[31] ? -48'(power_in) : 48'sh0;
            EPO_INT_NET: contrib = 48'(power_in);
            default: contrib = 48'sh0;
        endcase
    end

    assign acc_sum = acc_r + contrib;
    assign thr = 48'(cal_epp_r) * 48'(`EPO_WMS_PER_MWH);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= 48'sh0;
            cal_evt_r <= 1'b0;
        end else if (tick_r && acc_sum >= thr) begin
            acc_r <= acc_sum - thr;
            cal_evt_r <= 1'b1;
        end else begin
            if (tick_r) begin
                acc_r <= acc_sum;
            end
            cal_evt_r <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cal_count_r <= 16'h0000;
        end else if (cal_evt_r) begin
            cal_count_r <= cal_count_r + 16'h0001;
        end
    end

    // ============================================================
    // Pulse shapers.
    epo_pulse_shaper u_gen (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick_r),
        .event_in(pulse_in),
        .cfg('{width_ms: gen_width_r, kyz: gen_ctrl_r.kyz,
               invert: gen_ctrl_r.invert, gap: 1'b0}),
        .level(gen_lvl)
    );

    epo_pulse_shaper u_cal (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick_r),
        .event_in(cal_evt_r),
        .cfg('{width_ms: cal_width_r, kyz: cal_ctrl_r.kyz,
               invert: 1'b0, gap: 1'b1}),
        .level(cal_lvl)
    );

    epo_pulse_shaper u_led (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick_r),
        .event_in(cal_evt_r),
        .cfg('{width_ms: cal_width_r, kyz: 1'b0, invert: 1'b0, gap: 1'b1}),
        .level(led_lvl)
    );

    // ============================================================
    // Channel routing: unassigned channels stay low.
    for (genvar ch = 0; ch < 4; ch++) begin : g_chan
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                channel_r[ch] <= 1'b0;
            end else if (gen_ctrl_r.port == 3'(ch + 1)) begin
                channel_r[ch] <= gen_lvl;
            end else if (cal_ctrl_r.port == 3'(ch + 1)) begin
                channel_r[ch] <= cal_lvl;
            end else begin
                channel_r[ch] <= 1'b0;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            led_r <= 1'b0;
        end else begin
            led_r <= led_lvl;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata = hrdata_r;
    assign hresp = hresp_r;
    assign channel_out = channel_r;
    assign led_out = led_r;

endmodule
